//--- canifc_pkg.sv
// Package for the CAN interrupt and FIFO control block.
// Assumes one clock domain and a plain strobe register port.
package canifc_pkg;

	// Register byte offsets
	localparam logic [7:0] CANIFC_INT_OFS   = 8'h00;
	localparam logic [7:0] CANIFC_MAIN_OFS  = 8'h04;
	localparam logic [7:0] CANIFC_FIFO_OFS  = 8'h40;
	localparam int         CANIFC_NFIFO     = 16;

	// Interrupt register: enables in the upper half, flags in the lower
	localparam int CANIFC_IE_HI = 27;
	localparam int CANIFC_IE_LO = 16;
	localparam int CANIFC_IF_HI = 11;
	localparam int CANIFC_IF_LO = 0;
	localparam int CANIFC_NSRC  = 9;

	// Source indices inside the internal flag and enable vectors
	localparam int SRC_INVALID  = 8;
	localparam int SRC_WAKEUP   = 7;
	localparam int SRC_BUS_ERR  = 6;
	localparam int SRC_SYS_ERR  = 5;
	localparam int SRC_RX_OVF   = 4;
	localparam int SRC_MODE     = 3;
	localparam int SRC_TSTAMP   = 2;
	localparam int SRC_RX_BUF   = 1;
	localparam int SRC_TX_BUF   = 0;
	localparam logic [8:0] CANIFC_SRC_RST = 9'h000;

	// Main control register
	localparam int         CANIFC_ON_BIT     = 15;
	localparam int         CANIFC_OPMODE_HI  = 23;
	localparam int         CANIFC_OPMODE_LO  = 21;
	localparam logic [2:0] CANIFC_OPMODE_CFG = 3'h4;
	localparam logic [2:0] CANIFC_OPMODE_RST = 3'h4;
	localparam logic       CANIFC_ON_RST     = 1'b0;

	// FIFO control register fields
	localparam int CANIFC_F_DIR  = 7;
	localparam int CANIFC_F_ABAT = 6;
	localparam int CANIFC_F_LARB = 5;
	localparam int CANIFC_F_ERR  = 4;
	localparam int CANIFC_F_REQ  = 3;
	localparam int CANIFC_F_RTR  = 2;
	localparam int CANIFC_F_PRHI = 1;
	localparam int CANIFC_F_PRLO = 0;
	localparam logic [7:0] CANIFC_FIFO_RST = 8'h00;

	// Events from the protocol engine, one-cycle pulses
	typedef struct packed {
		logic invalid_msg;
		logic bus_activity;
		logic bus_error;
		logic system_error;
		logic rx_overflow;
		logic timestamp;
		logic rx_buffer;
		logic tx_buffer;
	} canifc_core_evt_s;

	typedef struct packed {
		logic fifo_reset;
		logic tx_all_done;
		logic tx_aborted;
		logic lost_arb;
		logic tx_error;
		logic rtr_rx;
	} canifc_fifo_evt_s;

endpackage

//--- canifc_fifo_ctl.sv
// One FIFO control register with its status and send-request logic.
// Assumes evt pulses come from the protocol engine in the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module canifc_fifo_ctl
	import canifc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             wr,
	input  wire logic             rd,
	input  wire logic [7:0]       wdata,
	input  wire logic             cfg_mode,
	input  wire canifc_fifo_evt_s evt,
	output logic [7:0]            rvalue,
	output logic                  send_req,
	output logic                  dir,
	output logic [1:0]            prio,
	output logic                  abort_req
);
	logic abat_reg;
	logic larb_reg;
	logic err_reg;
	logic rtr_reg;

	// Configuration-only bits
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dir     <= 1'b0;
			rtr_reg <= 1'b0;
			prio    <= 2'h0;
		end else if (wr && cfg_mode) begin
			dir     <= wdata[CANIFC_F_DIR];
			rtr_reg <= wdata[CANIFC_F_RTR];
			prio    <= wdata[CANIFC_F_PRHI:CANIFC_F_PRLO];
		end
	end

	// Setting beats completion; a receive FIFO never keeps a request
	always_ff @(posedge mclk) begin
		if (sys_rst || evt.fifo_reset) begin
			send_req <= 1'b0;
		end else if (dir && ((wr && wdata[CANIFC_F_REQ]) ||
				(evt.rtr_rx && rtr_reg))) begin
			send_req <= 1'b1;
		end else if (!dir || evt.tx_all_done || evt.tx_aborted) begin
			send_req <= 1'b0;
		end
	end

	// One-cycle pulse; the request bit waits for the engine's answer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			abort_req <= 1'b0;
		end else begin
			abort_req <= dir && wr && !wdata[CANIFC_F_REQ] && send_req;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || evt.fifo_reset) begin
			abat_reg <= 1'b0;
		end else if (evt.tx_aborted) begin
			abat_reg <= 1'b1;
		end else if (evt.tx_all_done) begin
			abat_reg <= 1'b0;
		end
	end

	// Read clear loses to a new event
	always_ff @(posedge mclk) begin
		if (sys_rst || evt.fifo_reset) begin
			larb_reg <= 1'b0;
			err_reg  <= 1'b0;
		end else begin
			larb_reg <= evt.lost_arb || (larb_reg && !rd);
			err_reg  <= evt.tx_error || (err_reg && !rd);
		end
	end

	assign rvalue = {dir, abat_reg, larb_reg, err_reg,
		send_req, rtr_reg, prio};

	a_rx_req_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
		!dir && !evt.fifo_reset |=> !send_req)
		else $error("send request set in a receive FIFO");

	a_larb_rd_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		rd && !evt.lost_arb |=> !larb_reg)
		else $error("lost arbitration not cleared by read");

	a_abort_on_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		dir && send_req && wr && !wdata[CANIFC_F_REQ] |=> abort_req)
		else $error("abort not requested on send request clear");

endmodule // canifc_fifo_ctl
`default_nettype wire

//--- canifc_top.sv
// CAN interrupt register, main control and per-FIFO control registers.
// Assumes a one-cycle strobe register port and engine events on mclk.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module canifc_top
	import canifc_pkg::*;
#(
	parameter int NFIFO = CANIFC_NFIFO,
	parameter int IW    = $clog2(NFIFO)
)(
	input  wire logic                          mclk,
	input  wire logic                          sys_rst,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [31:0]                        reg_rdata,
	input  wire canifc_core_evt_s              core_evt,
	input  wire canifc_fifo_evt_s [NFIFO-1:0]  fifo_evt,
	output logic                               can_irq,
	output logic                               module_on,
	output logic [2:0]                         operating_mode_field,
	output logic [NFIFO-1:0]                   fifo_direction_select,
	output logic [NFIFO-1:0]                   send_request,
	output logic [NFIFO-1:0]                   abort_request,
	output logic                               tx_pending,
	output logic [IW-1:0]                      tx_fifo_sel,
	output logic [1:0]                         tx_fifo_prio
);
	logic [CANIFC_NSRC-1:0] flag_reg;
	logic [CANIFC_NSRC-1:0] flag_next;
	logic [CANIFC_NSRC-1:0] en_reg;
	logic [CANIFC_NSRC-1:0] hw_set;
	logic [CANIFC_NSRC-1:0] wr_flags;
	logic [CANIFC_NSRC-1:0] wr_ens;
	logic                   int_sel;
	logic                   main_sel;
	logic                   fifo_sel;
	logic [7:0]             fifo_ofs;
	logic [IW-1:0]          fifo_idx;
	logic                   mode_change;
	logic                   turn_off;
	logic                   cfg_mode;
	logic [31:0]            int_value;
	logic [31:0]            main_value;
	logic [31:0]            rdata_next;
	logic [7:0]             fifo_rvalue [NFIFO];
	logic [1:0]             fifo_prio [NFIFO];
	logic                   pend_next;
	logic [IW-1:0]          sel_next;
	logic [1:0]             best_next;

	// Address decode
	assign fifo_ofs = reg_addr - CANIFC_FIFO_OFS;
	assign int_sel  = (reg_addr == CANIFC_INT_OFS);
	assign main_sel = (reg_addr == CANIFC_MAIN_OFS);
	assign fifo_idx = fifo_ofs[IW+1:2];
	assign fifo_sel = (reg_addr >= CANIFC_FIFO_OFS) &&
		(fifo_ofs[1:0] == 2'h0) &&
		(({24'h0, fifo_ofs} >> 2) < 32'(NFIFO));

	assign cfg_mode = (operating_mode_field == CANIFC_OPMODE_CFG);

	// Software view of the sparse flag and enable fields
	assign wr_flags = {reg_wdata[15:CANIFC_IF_HI], reg_wdata[3:CANIFC_IF_LO]};
	assign wr_ens   = {reg_wdata[31:CANIFC_IE_HI], reg_wdata[19:CANIFC_IE_LO]};

	// Main control: on bit and operating mode
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			module_on            <= CANIFC_ON_RST;
			operating_mode_field <= CANIFC_OPMODE_RST;
		end else if (reg_wr && main_sel) begin
			module_on            <= reg_wdata[CANIFC_ON_BIT];
			operating_mode_field <=
				reg_wdata[CANIFC_OPMODE_HI:CANIFC_OPMODE_LO];
		end
	end

	assign mode_change = reg_wr && main_sel && (operating_mode_field !=
		reg_wdata[CANIFC_OPMODE_HI:CANIFC_OPMODE_LO]);
	assign turn_off = reg_wr && main_sel && module_on &&
		!reg_wdata[CANIFC_ON_BIT];

	// Hardware events in source order
	always_comb begin
		hw_set               = '0;
		hw_set[SRC_INVALID]  = core_evt.invalid_msg;
		hw_set[SRC_WAKEUP]   = core_evt.bus_activity;
		hw_set[SRC_BUS_ERR]  = core_evt.bus_error;
		hw_set[SRC_SYS_ERR]  = core_evt.system_error;
		hw_set[SRC_RX_OVF]   = core_evt.rx_overflow;
		hw_set[SRC_MODE]     = mode_change;
		hw_set[SRC_TSTAMP]   = core_evt.timestamp;
		hw_set[SRC_RX_BUF]   = core_evt.rx_buffer;
		hw_set[SRC_TX_BUF]   = core_evt.tx_buffer;
	end

	// Set wins over a write in the same cycle
	always_comb begin
		flag_next = flag_reg;
		if (reg_wr && int_sel) begin
			flag_next = wr_flags;
			flag_next[SRC_SYS_ERR] = flag_reg[SRC_SYS_ERR];
		end
		if (turn_off) begin
			flag_next[SRC_SYS_ERR] = 1'b0;
		end
		flag_next = flag_next | hw_set;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flag_reg <= CANIFC_SRC_RST;
		end else begin
			flag_reg <= flag_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			en_reg <= CANIFC_SRC_RST;
		end else if (reg_wr && int_sel) begin
			en_reg <= wr_ens;
		end
	end

	// Registered so the line never glitches
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			can_irq <= 1'b0;
		end else begin
			can_irq <= |(flag_reg & en_reg);
		end
	end

	// Unused positions forced to zero
	assign int_value = {en_reg[8:4], 7'h00, en_reg[3:0],
		flag_reg[8:4], 7'h00, flag_reg[3:0]};
	assign main_value = {8'h00, operating_mode_field, 5'h00,
		module_on, 15'h0000};

	// FIFO control instances
	genvar g;
	generate
		for (g = 0; g < NFIFO; g++) begin : g_fifo
			canifc_fifo_ctl u_fifo (
				.mclk      (mclk),
				.sys_rst   (sys_rst),
				.wr        (reg_wr && fifo_sel && (fifo_idx == IW'(g))),
				.rd        (reg_rd && fifo_sel && (fifo_idx == IW'(g))),
				.wdata     (reg_wdata[7:0]),
				.cfg_mode  (cfg_mode),
				.evt       (fifo_evt[g]),
				.rvalue    (fifo_rvalue[g]),
				.send_req  (send_request[g]),
				.dir       (fifo_direction_select[g]),
				.prio      (fifo_prio[g]),
				.abort_req (abort_request[g])
			);
		end
	endgenerate

	// Highest priority wins, lowest index breaks a tie
	always_comb begin
		pend_next = 1'b0;
		sel_next  = '0;
		best_next = 2'h0;
		for (int i = 0; i < NFIFO; i++) begin
			if (send_request[i] && fifo_direction_select[i] &&
					(!pend_next || fifo_prio[i] > best_next)) begin
				pend_next = 1'b1;
				sel_next  = IW'(i);
				best_next = fifo_prio[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_pending   <= 1'b0;
			tx_fifo_sel  <= '0;
			tx_fifo_prio <= 2'h0;
		end else begin
			tx_pending   <= pend_next;
			tx_fifo_sel  <= sel_next;
			tx_fifo_prio <= best_next;
		end
	end

	// Read mux; unmapped addresses answer zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (int_sel) begin
			rdata_next = int_value;
		end else if (main_sel) begin
			rdata_next = main_value;
		end else if (fifo_sel) begin
			rdata_next = {24'h00_0000, fifo_rvalue[fifo_idx]};
		end
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	a_invalid_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
		core_evt.invalid_msg |=> flag_reg[SRC_INVALID])
		else $error("invalid message flag not set");

	a_wake_irq_path: assert property (@(posedge mclk) disable iff (sys_rst)
		core_evt.bus_activity && en_reg[SRC_WAKEUP] &&
		!(reg_wr && int_sel) |=> ##1 can_irq)
		else $error("wake-up did not raise the interrupt");

	a_irq_masked: assert property (@(posedge mclk) disable iff (sys_rst)
		(flag_reg & en_reg) == '0 |=> !can_irq)
		else $error("interrupt without enabled flag");

	a_bus_err_irq: assert property (@(posedge mclk) disable iff (sys_rst)
		flag_reg[SRC_BUS_ERR] && en_reg[SRC_BUS_ERR] |=> can_irq)
		else $error("bus error interrupt missing");

	a_sys_err_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		flag_reg[SRC_SYS_ERR] && !turn_off |=> flag_reg[SRC_SYS_ERR])
		else $error("system error flag cleared without off");

	a_sys_err_off: assert property (@(posedge mclk) disable iff (sys_rst)
		turn_off && !core_evt.system_error |=> !flag_reg[SRC_SYS_ERR])
		else $error("system error flag kept after off");

	a_unused_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && int_sel |=>
		reg_rdata[26:20] == 7'h00 && reg_rdata[10:4] == 7'h00)
		else $error("unused interrupt bits read nonzero");

	a_mode_flag_set: assert property (@(posedge mclk) disable iff (sys_rst)
		mode_change |=> flag_reg[SRC_MODE])
		else $error("mode change flag not set");

	a_tx_sel_valid: assert property (@(posedge mclk) disable iff (sys_rst)
		send_request[0] && fifo_direction_select[0] |=>
		tx_pending && tx_fifo_prio >= $past(fifo_prio[0]))
		else $error("transmit selection lost");

	a_cfg_lock: assert property (@(posedge mclk) disable iff (sys_rst)
		!cfg_mode |=> $stable(fifo_direction_select))
		else $error("direction changed outside configuration mode");

endmodule // canifc_top
`default_nettype wire

//--- canifc_engine_bfm.sv
// Behavioural protocol engine model facing the FIFO control block.
// Assumes the block's pending flag, selection and abort pulses on mclk.
`timescale 1ns/100ps
`default_nettype none
module canifc_engine_bfm
	import canifc_pkg::*;
#(
	parameter int NF = 4,
	parameter int W  = 2
)(
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	input  wire logic [7:0]           lat,
	input  wire logic                 tx_pending,
	input  wire logic [W-1:0]         tx_fifo_sel,
	input  wire logic [NF-1:0]        abort_request,
	output var  canifc_fifo_evt_s [NF-1:0] evt
);
	logic         busy_reg;
	logic [W-1:0] cur_reg;
	logic [7:0]   cnt_reg;

	// Cool-down after each message: the pending flag lags by a cycle or two
	always_ff @(posedge mclk) begin
		evt <= '0;
		if (sys_rst) begin
			busy_reg <= 1'b0;
			cur_reg  <= '0;
			cnt_reg  <= 8'h00;
		end else if (busy_reg && abort_request[cur_reg]) begin
			busy_reg <= 1'b0;
			cnt_reg  <= 8'h03;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 8'h01;
			if (cnt_reg == lat) begin
				evt[cur_reg].tx_all_done <= 1'b1;
				busy_reg <= 1'b0;
				cnt_reg  <= 8'h03;
			end
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else if (tx_pending) begin
			busy_reg <= 1'b1;
			cur_reg  <= tx_fifo_sel;
		end
		for (int i = 0; i < NF; i++) begin
			if (abort_request[i] && !sys_rst) begin
				evt[i].tx_aborted <= 1'b1;
			end
		end
	end
endmodule // canifc_engine_bfm
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the CAN interrupt and FIFO control block.
// Assumes the strobe register port and the engine model beside it.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import canifc_pkg::*;
;
	localparam int NF = 4;
	typedef struct packed {
		logic [7:0]  ev;
		logic [31:0] fl;
		logic [31:0] en;
	} canifc_row_s;
	logic                      mclk;
	logic                      sys_rst;
	logic [7:0]                reg_addr;
	logic [7:0]                lat;
	logic [31:0]               reg_wdata;
	logic [31:0]               reg_rdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic                      can_irq;
	logic                      tx_pending;
	logic                      seen;
	logic                      mon;
	logic [2:0]                opm;
	logic [NF-1:0]             dir;
	logic [NF-1:0]             sreq;
	logic [NF-1:0]             areq;
	logic [1:0]                tprio;
	logic [1:0]                tsel;
	canifc_core_evt_s          core_evt;
	canifc_fifo_evt_s [NF-1:0] pevt;
	canifc_fifo_evt_s [NF-1:0] tevt;
	canifc_fifo_evt_s [NF-1:0] fevt;
	int                        error_cnt;
	int                        samples_checked;
	// System error row last: its flag cannot be cleared by a write
	canifc_row_s rows [8] = '{
		'{8'h80, 32'h0000_8000, 32'h8000_0000},
		'{8'h40, 32'h0000_4000, 32'h4000_0000},
		'{8'h20, 32'h0000_2000, 32'h2000_0000},
		'{8'h08, 32'h0000_0800, 32'h0800_0000},
		'{8'h04, 32'h0000_0004, 32'h0004_0000},
		'{8'h02, 32'h0000_0002, 32'h0002_0000},
		'{8'h01, 32'h0000_0001, 32'h0001_0000},
		'{8'h10, 32'h0000_1000, 32'h1000_0000}};
	assign fevt = pevt | tevt;

	canifc_top #(.NFIFO(NF)) uut (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt),
		.fifo_evt(fevt), .can_irq(can_irq), .module_on(mon),
		.operating_mode_field(opm), .fifo_direction_select(dir),
		.send_request(sreq), .abort_request(areq),
		.tx_pending(tx_pending), .tx_fifo_sel(tsel), .tx_fifo_prio(tprio));
	canifc_engine_bfm #(.NF(NF), .W(2)) bfm (.mclk(mclk), .sys_rst(sys_rst),
		.lat(lat), .tx_pending(tx_pending), .tx_fifo_sel(tsel),
		.abort_request(areq), .evt(pevt));

	task automatic give_verdict();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#10;
		chk(nm, e, reg_rdata);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge mclk);
		core_evt <= canifc_core_evt_s'(v);
		@(posedge mclk);
		core_evt <= '0;
	endtask
	task automatic fpulse(input int i, input logic [5:0] v);
		@(posedge mclk);
		tevt[i] <= canifc_fifo_evt_s'(v);
		@(posedge mclk);
		tevt <= '0;
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 600 && sreq !== 4'h0; k++) cyc(1);
		chk("sreq idle", 32'h0, {28'h0, sreq});
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2000000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		sys_rst         = 1'b1;
		reg_addr        = 8'h00;
		reg_wdata       = 32'h0;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		lat             = 8'h28;
		core_evt        = '0;
		tevt            = '0;
		error_cnt       = 0;
		samples_checked = 0;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(CANIFC_MAIN_OFS, 32'h0080_0000, "main rst");
		rd(CANIFC_INT_OFS, 32'h0, "int rst");
		foreach (rows[i]) begin
			wr(CANIFC_INT_OFS, 32'h0);
			pulse(rows[i].ev);
			rd(CANIFC_INT_OFS, rows[i].fl, "flag");
			chk("irq masked", 32'h0, {31'h0, can_irq});
			wr(CANIFC_INT_OFS, rows[i].fl | rows[i].en);
			cyc(2);
			chk("irq on", 32'h1, {31'h0, can_irq});
		end
		wr(CANIFC_INT_OFS, 32'h0);
		rd(CANIFC_INT_OFS, 32'h0000_1000, "syserr kept");
		wr(CANIFC_MAIN_OFS, 32'h0080_8000);
		#10;
		chk("on", 32'h1, {31'h0, mon});
		wr(CANIFC_MAIN_OFS, 32'h0080_0000);
		rd(CANIFC_INT_OFS, 32'h0, "syserr off");
		wr(CANIFC_INT_OFS, 32'hFFFF_FFFF);
		rd(CANIFC_INT_OFS, 32'hF80F_E80F, "int unused");
		wr(CANIFC_INT_OFS, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, "unmapped");
		wr(8'h40, 32'h81);
		wr(8'h44, 32'h83);
		wr(8'h48, 32'h83);
		cyc(1);
		chk("dir", 32'h7, {28'h0, dir});
		rd(8'h44, 32'h83, "fifo1");
		wr(8'h40, 32'h89);
		wr(8'h44, 32'h8B);
		wr(8'h48, 32'h8B);
		wr(8'h4C, 32'h08);
		cyc(2);
		chk("sreq", 32'h7, {28'h0, sreq});
		chk("sel", 32'h1, {30'h0, tsel});
		chk("prio", 32'h3, {30'h0, tprio});
		chk("pend", 32'h1, {31'h0, tx_pending});
		wait_idle();
		rd(8'h44, 32'h83, "done abat");
		wr(8'h40, 32'h89);
		wr(8'h40, 32'h81);
		seen = 1'b0;
		repeat (3) begin
			#10;
			seen = seen | areq[0];
			@(posedge mclk);
		end
		chk("abort", 32'h1, {31'h0, seen});
		wait_idle();
		rd(8'h40, 32'hC1, "abat");
		fpulse(1, 6'h04);
		fpulse(1, 6'h02);
		rd(8'h44, 32'hB3, "larb err");
		rd(8'h44, 32'h83, "rd clear");
		fpulse(0, 6'h04);
		fpulse(0, 6'h20);
		rd(8'h40, 32'h81, "fifo reset");
		wr(8'h48, 32'h87);
		fpulse(1, 6'h01);
		fpulse(2, 6'h01);
		cyc(1);
		chk("rtr", 32'h4, {28'h0, sreq});
		wait_idle();
		wr(CANIFC_MAIN_OFS, 32'h0);
		rd(CANIFC_INT_OFS, 32'h8, "mode flag");
		wr(CANIFC_INT_OFS, 32'h0008_0008);
		cyc(2);
		chk("mode irq", 32'h1, {31'h0, can_irq});
		wr(8'h40, 32'h0);
		rd(8'h40, 32'h81, "cfg lock");
		wr(CANIFC_INT_OFS, 32'h4000_0000);
		cyc(1);
		chk("wake masked", 32'h0, {31'h0, can_irq});
		pulse(8'h40);
		cyc(1);
		chk("wake irq", 32'h1, {31'h0, can_irq});
		@(posedge mclk);
		sys_rst <= 1'b1;
		@(posedge mclk);
		sys_rst <= 1'b0;
		cyc(1);
		chk("rst mode", 32'h4, {29'h0, opm});
		chk("rst dir", 32'h0, {28'h0, dir});
		chk("rst irq", 32'h0, {31'h0, can_irq});
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
